// file: logic/pscfc_cfg.svh
`ifndef PSCFC_CFG_SVH
`define PSCFC_CFG_SVH

// Line levels: mark is logic one, space is logic zero.
`define PSC_MARK            1'b1
`define PSC_SPACE           1'b0

// Clock and oversampling.
`define PSC_CLK_HZ          50000000
`define PSC_CYC_PER_MS      (`PSC_CLK_HZ / 1000)
`define PSC_OVS             16
`define PSC_OVS_MID         4'h7
`define PSC_OVS_LAST        4'hF
`define PSC_DIV_W           16

// Baud rates.
`define PSC_BAUD_300        300
`define PSC_BAUD_600        600
`define PSC_BAUD_1200       1200
`define PSC_BAUD_2400       2400
`define PSC_BAUD_4800       4800
`define PSC_BAUD_9600       9600
`define PSC_BAUD_19200      19200

// Character framing.
`define PSC_LAST_BIT8       3'h7
`define PSC_LAST_BIT7       3'h6
`define PSC_FRAME_BITS8     4'h9
`define PSC_FRAME_BITS7     4'h8

// Flow control characters and timing.
`define PSC_XON_CHAR        8'h11
`define PSC_XOFF_CHAR       8'h13
`define PSC_XON_PERIOD_MS   1000
`define PSC_MIN_BUSY_S_MS   200
`define PSC_MIN_BUSY_L_MS   1000
`define PSC_TMR_W           26

// Receive FIFO.
`define PSC_FIFO_W          8
`define PSC_FIFO_DEPTH      16
`define PSC_FIFO_AW         4
`define PSC_FIFO_HIGH       5'h0C
`define PSC_FIFO_LOW        5'h04

// Configuration reset values.
`define PSC_FLOW_RST        2'h0
`define PSC_BAUD_RST        3'h5
`define PSC_LEN7_RST        1'b0
`define PSC_PAR_RST         2'h0

`endif

// file: logic/pscfc_pkg.sv
`default_nettype none
package pscfc_pkg;
  typedef enum logic [1:0] {
    FLOW_READY_ON_SPACE,
    FLOW_READY_ON_MARK,
    FLOW_XONXOFF,
    FLOW_READY_BUSY_WITH_PERIODIC_RESUME
  } pscfc_flow_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSVD} pscfc_par_t;
  typedef enum logic [2:0] {
    BAUD_300, BAUD_600, BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200, BAUD_RSVD
  } pscfc_baud_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} pscfc_rx_state_t;
endpackage
`default_nettype wire

// file: logic/pscfc_ser_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pscfc_ser_if;
  logic                  tick;
  logic                  len7;
  pscfc_pkg::pscfc_par_t par;
  modport src (output tick, output len7, output par);
  modport snk (input tick, input len7, input par);
endinterface
`default_nettype wire

// file: logic/pscfc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pscfc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  // Fill side.
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side.
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  always_comb begin
    in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    out_valid = (cnt_ff != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_wr    = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd    = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    out_data  = mem[rd_ff];
    level     = cnt_ff;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // The storage has no reset; only the pointers must be defined.
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: logic/pscfc_tx.sv
`include "pscfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pscfc_tx (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // Line settings.
  pscfc_ser_if.snk        ser,
  // Character request.
  input  wire logic       send_valid,
  output logic            send_ready,
  input  wire logic [7:0] send_data,
  // Line.
  output logic            tx_line
);
  logic [10:0] sh_ff, nxt_sh, frm;
  logic [3:0]  left_ff, nxt_left, ovs_ff, nxt_ovs, nb;
  logic [7:0]  d;
  logic        pb;

  always_comb begin
    d   = ser.len7 ? {1'b0, send_data[6:0]} : send_data;
    pb  = (^d) ^ (ser.par == pscfc_pkg::PAR_ODD);
    frm = {11{`PSC_MARK}};
    frm[0] = `PSC_SPACE;
    frm[8:1] = d;
    nb = ser.len7 ? `PSC_FRAME_BITS7 : `PSC_FRAME_BITS8;
    if (ser.len7) begin
      frm[8] = `PSC_MARK;
    end
    if (ser.par != pscfc_pkg::PAR_NONE) begin
      frm[nb] = pb;
      nb = nb + 4'h1;
    end
    send_ready = (left_ff == '0);
    nxt_sh   = sh_ff;
    nxt_left = left_ff;
    nxt_ovs  = ovs_ff;
    if (send_valid && send_ready) begin
      nxt_sh   = frm;
      nxt_left = nb + 4'h1;
      nxt_ovs  = '0;
    end else if (left_ff != '0 && ser.tick) begin
      nxt_ovs = ovs_ff + 4'h1;
      if (ovs_ff == `PSC_OVS_LAST) begin
        nxt_sh   = {`PSC_MARK, sh_ff[10:1]};
        nxt_left = left_ff - 4'h1;
      end
    end
    tx_line = sh_ff[0];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sh_ff   <= {11{`PSC_MARK}};
      left_ff <= '0;
      ovs_ff  <= '0;
    end else if (clk_en) begin
      sh_ff   <= nxt_sh;
      left_ff <= nxt_left;
      ovs_ff  <= nxt_ovs;
    end
  end
endmodule
`default_nettype wire

// file: logic/pscfc_top.sv
`include "pscfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pscfc_top #(
  parameter int XON_PERIOD_CYC  = `PSC_XON_PERIOD_MS * `PSC_CYC_PER_MS,
  parameter int MIN_BUSY_S_CYC  = `PSC_MIN_BUSY_S_MS * `PSC_CYC_PER_MS,
  parameter int MIN_BUSY_L_CYC  = `PSC_MIN_BUSY_L_MS * `PSC_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Serial pins.
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             rts_pin,
  output logic             dtr_pin,
  // Settings from the nonvolatile store.
  input  wire logic        cfg_load,
  input  wire logic [1:0]  nv_flow_control_select,
  input  wire logic [2:0]  nv_baud_select,
  input  wire logic        nv_len7,
  input  wire logic [1:0]  nv_parity_select,
  input  wire logic        nv_min_busy_long,
  input  wire logic        min_busy_enable,
  // Settings in force, for writing back to the store.
  output logic [1:0]       flow_control_select,
  output logic [2:0]       baud_select,
  output logic             len7,
  output logic [1:0]       parity_select,
  output logic             min_busy_long,
  // Received characters.
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data,
  // Status.
  output logic             busy,
  output logic             parity_error,
  output logic             framing_error,
  output logic             overrun
);
  // Configuration group.
  pscfc_pkg::pscfc_flow_t flow_ff, nxt_flow;
  pscfc_pkg::pscfc_baud_t baud_ff, nxt_baud;
  pscfc_pkg::pscfc_par_t  par_ff, nxt_par;
  logic                   len7_ff, nxt_len7, mbl_ff, nxt_mbl;

  always_comb begin
    nxt_flow = flow_ff;
    nxt_baud = baud_ff;
    nxt_par  = par_ff;
    nxt_len7 = len7_ff;
    nxt_mbl  = mbl_ff;
    if (cfg_load) begin
      nxt_flow = pscfc_pkg::pscfc_flow_t'(nv_flow_control_select);
      nxt_baud = pscfc_pkg::pscfc_baud_t'(nv_baud_select);
      nxt_par  = pscfc_pkg::pscfc_par_t'(nv_parity_select);
      nxt_len7 = nv_len7;
      nxt_mbl  = nv_min_busy_long;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flow_ff <= pscfc_pkg::pscfc_flow_t'(`PSC_FLOW_RST);
      baud_ff <= pscfc_pkg::pscfc_baud_t'(`PSC_BAUD_RST);
      par_ff  <= pscfc_pkg::pscfc_par_t'(`PSC_PAR_RST);
      len7_ff <= `PSC_LEN7_RST;
      mbl_ff  <= 1'b0;
    end else if (clk_en) begin
      flow_ff <= nxt_flow;
      baud_ff <= nxt_baud;
      par_ff  <= nxt_par;
      len7_ff <= nxt_len7;
      mbl_ff  <= nxt_mbl;
    end
  end

  assign flow_control_select = flow_ff;
  assign baud_select         = baud_ff;
  assign len7                = len7_ff;
  assign parity_select       = par_ff;
  assign min_busy_long       = mbl_ff;

  // Oversampling tick at sixteen times the bit rate.
  pscfc_ser_if ser ();
  logic [`PSC_DIV_W-1:0] div, bcnt_ff, nxt_bcnt;

  always_comb begin
    unique case (baud_ff)
      pscfc_pkg::BAUD_300:   div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_300));
      pscfc_pkg::BAUD_600:   div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_600));
      pscfc_pkg::BAUD_1200:  div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_1200));
      pscfc_pkg::BAUD_2400:  div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_2400));
      pscfc_pkg::BAUD_4800:  div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_4800));
      pscfc_pkg::BAUD_19200: div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_19200));
      default:               div = `PSC_DIV_W'(`PSC_CLK_HZ / (`PSC_OVS * `PSC_BAUD_9600));
    endcase
    ser.tick = (bcnt_ff >= div - `PSC_DIV_W'(1));
    nxt_bcnt = (ser.tick || cfg_load) ? '0 : bcnt_ff + `PSC_DIV_W'(1);
    ser.len7 = len7_ff;
    ser.par  = par_ff;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bcnt_ff <= '0;
    end else if (clk_en) begin
      bcnt_ff <= nxt_bcnt;
    end
  end

  // Receive line synchroniser; the line idles at mark.
  logic rx_m_ff, rx_s_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_m_ff <= `PSC_MARK;
      rx_s_ff <= `PSC_MARK;
    end else if (clk_en) begin
      rx_m_ff <= rx_pin;
      rx_s_ff <= rx_m_ff;
    end
  end

  // Receiver.
  pscfc_pkg::pscfc_rx_state_t st_ff, nxt_st;
  logic [3:0] ovs_ff, nxt_ovs;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh, dat_ff, nxt_dat;
  logic       push_ff, nxt_push, perr_ff, nxt_perr, ferr_ff, nxt_ferr, ovr_ff, nxt_ovr;
  logic       pacc_ff, nxt_pacc, fifo_in_ready;
  logic [`PSC_FIFO_AW:0] level;

  always_comb begin
    nxt_st   = st_ff;
    nxt_ovs  = ovs_ff;
    nxt_bit  = bit_ff;
    nxt_sh   = sh_ff;
    nxt_dat  = dat_ff;
    nxt_pacc = pacc_ff;
    nxt_push = 1'b0;
    nxt_perr = 1'b0;
    nxt_ferr = 1'b0;
    nxt_ovr  = push_ff && !fifo_in_ready;
    unique case (st_ff)
      pscfc_pkg::RX_IDLE: begin
        if (rx_s_ff == `PSC_SPACE) begin
          nxt_st  = pscfc_pkg::RX_START;
          nxt_ovs = '0;
        end
      end
      pscfc_pkg::RX_START: begin
        if (ser.tick) begin
          nxt_ovs = ovs_ff + 4'h1;
          // Sampling half a bit in leaves nearly half a bit of margin each way.
          if (ovs_ff == `PSC_OVS_MID) begin
            nxt_ovs  = '0;
            nxt_bit  = '0;
            nxt_pacc = (par_ff == pscfc_pkg::PAR_ODD);
            nxt_st   = (rx_s_ff == `PSC_SPACE) ? pscfc_pkg::RX_DATA : pscfc_pkg::RX_IDLE;
          end
        end
      end
      pscfc_pkg::RX_DATA: begin
        if (ser.tick) begin
          nxt_ovs = ovs_ff + 4'h1;
          if (ovs_ff == `PSC_OVS_LAST) begin
            nxt_sh   = {rx_s_ff, sh_ff[7:1]};
            nxt_pacc = pacc_ff ^ rx_s_ff;
            nxt_bit  = bit_ff + 3'h1;
            if (bit_ff == (len7_ff ? `PSC_LAST_BIT7 : `PSC_LAST_BIT8)) begin
              nxt_st = (par_ff == pscfc_pkg::PAR_NONE) ? pscfc_pkg::RX_STOP
                                                        : pscfc_pkg::RX_PAR;
            end
          end
        end
      end
      pscfc_pkg::RX_PAR: begin
        if (ser.tick) begin
          nxt_ovs = ovs_ff + 4'h1;
          if (ovs_ff == `PSC_OVS_LAST) begin
            nxt_pacc = pacc_ff ^ rx_s_ff;
            nxt_st   = pscfc_pkg::RX_STOP;
          end
        end
      end
      pscfc_pkg::RX_STOP: begin
        if (ser.tick) begin
          nxt_ovs = ovs_ff + 4'h1;
          if (ovs_ff == `PSC_OVS_LAST) begin
            nxt_st  = pscfc_pkg::RX_IDLE;
            nxt_dat = len7_ff ? {1'b0, sh_ff[7:1]} : sh_ff;
            // A character with a bad stop bit is dropped rather than stored.
            nxt_ferr = (rx_s_ff != `PSC_MARK);
            nxt_push = (rx_s_ff == `PSC_MARK);
            nxt_perr = (par_ff != pscfc_pkg::PAR_NONE) && pacc_ff;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= pscfc_pkg::RX_IDLE;
      ovs_ff  <= '0;
      bit_ff  <= '0;
      sh_ff   <= '0;
      dat_ff  <= '0;
      pacc_ff <= 1'b0;
      push_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      ovr_ff  <= 1'b0;
    end else if (clk_en) begin
      st_ff   <= nxt_st;
      ovs_ff  <= nxt_ovs;
      bit_ff  <= nxt_bit;
      sh_ff   <= nxt_sh;
      dat_ff  <= nxt_dat;
      pacc_ff <= nxt_pacc;
      push_ff <= nxt_push;
      perr_ff <= nxt_perr;
      ferr_ff <= nxt_ferr;
      ovr_ff  <= nxt_ovr;
    end
  end

  assign parity_error  = perr_ff;
  assign framing_error = ferr_ff;
  assign overrun       = ovr_ff;

  pscfc_fifo #(
    .W     (`PSC_FIFO_W),
    .DEPTH (`PSC_FIFO_DEPTH),
    .AW    (`PSC_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (dat_ff),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .level     (level)
  );

  // Flow control.
  logic                  busy_ff, nxt_busy, dtr_ff, nxt_dtr;
  logic                  pxon_ff, nxt_pxon, pxoff_ff, nxt_pxoff;
  logic [`PSC_TMR_W-1:0] hold_ff, nxt_hold, per_ff, nxt_per;
  logic                  send_ready, send_go, use_sw;

  always_comb begin
    nxt_busy  = busy_ff;
    nxt_hold  = (hold_ff != '0) ? hold_ff - `PSC_TMR_W'(1) : hold_ff;
    use_sw    = (flow_ff == pscfc_pkg::FLOW_XONXOFF);
    send_go   = (pxon_ff || pxoff_ff) && send_ready;
    nxt_pxoff = pxoff_ff && !(send_go && busy_ff);
    nxt_pxon  = pxon_ff && !(send_go && !busy_ff);
    nxt_per   = per_ff;
    if (!busy_ff && level >= `PSC_FIFO_HIGH) begin
      nxt_busy  = 1'b1;
      // The hold only applies when the page-description personality enables it.
      nxt_hold  = !min_busy_enable ? '0 :
                  mbl_ff ? `PSC_TMR_W'(MIN_BUSY_L_CYC) : `PSC_TMR_W'(MIN_BUSY_S_CYC);
      nxt_pxoff = use_sw;
      nxt_pxon  = 1'b0;
    end else if (busy_ff && hold_ff == '0 && level <= `PSC_FIFO_LOW) begin
      nxt_busy  = 1'b0;
      nxt_pxon  = use_sw || (flow_ff == pscfc_pkg::FLOW_READY_BUSY_WITH_PERIODIC_RESUME);
      nxt_pxoff = 1'b0;
    end
    if (flow_ff == pscfc_pkg::FLOW_READY_BUSY_WITH_PERIODIC_RESUME && !busy_ff) begin
      nxt_per = per_ff + `PSC_TMR_W'(1);
      if (per_ff >= `PSC_TMR_W'(XON_PERIOD_CYC - 1)) begin
        nxt_per  = '0;
        nxt_pxon = 1'b1;
      end
    end else begin
      nxt_per = '0;
    end
    // The ready level is space unless ready-on-mark is chosen.
    nxt_dtr = (flow_ff == pscfc_pkg::FLOW_READY_ON_MARK) ? (busy_ff ? `PSC_SPACE : `PSC_MARK)
                                                         : (busy_ff ? `PSC_MARK : `PSC_SPACE);
    if (use_sw) begin
      nxt_dtr = `PSC_SPACE;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_ff  <= 1'b0;
      hold_ff  <= '0;
      per_ff   <= '0;
      pxon_ff  <= 1'b0;
      pxoff_ff <= 1'b0;
      dtr_ff   <= `PSC_SPACE;
    end else if (clk_en) begin
      busy_ff  <= nxt_busy;
      hold_ff  <= nxt_hold;
      per_ff   <= nxt_per;
      pxon_ff  <= nxt_pxon;
      pxoff_ff <= nxt_pxoff;
      dtr_ff   <= nxt_dtr;
    end
  end

  assign busy    = busy_ff;
  assign dtr_pin = dtr_ff;
  assign rts_pin = `PSC_SPACE;

  pscfc_tx u_tx (
    .clock      (clock),
    .nrst       (nrst),
    .clk_en     (clk_en),
    .ser        (ser.snk),
    .send_valid (pxon_ff || pxoff_ff),
    .send_ready (send_ready),
    .send_data  (busy_ff ? `PSC_XOFF_CHAR : `PSC_XON_CHAR),
    .tx_line    (tx_pin)
  );
endmodule
`default_nettype wire

// file: verification/pscfc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pscfc_top_properties #(
  parameter int MIN_BUSY_S_CYC = 500,
  parameter int MIN_BUSY_L_CYC = 1500
) (
  // Clock and reset.
  input wire logic       clock,
  input wire logic       nrst,
  // Pins and status.
  input wire logic       rts_pin,
  input wire logic       dtr_pin,
  input wire logic       busy,
  input wire logic       parity_error,
  input wire logic       framing_error,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  // Settings.
  input wire logic       cfg_load,
  input wire logic [1:0] nv_flow_control_select,
  input wire logic [2:0] nv_baud_select,
  input wire logic       nv_len7,
  input wire logic       min_busy_enable,
  input wire logic [1:0] flow_control_select,
  input wire logic [2:0] baud_select,
  input wire logic       len7,
  input wire logic       min_busy_long
);
  int busy_run_ff;
  int nxt_busy_run;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Length of the busy stretch, so that a release can be judged against the hold.
  always_comb begin
    nxt_busy_run = busy ? busy_run_ff + 1 : 0;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) busy_run_ff <= 0;
    else busy_run_ff <= nxt_busy_run;
  end

  a_dtr_space_ready: assert property ((flow_control_select inside {2'h0, 2'h3}) [*2]
    |-> dtr_pin == $past(busy)) else $error("dtr wrong in space mode");
  a_dtr_mark_ready: assert property ((flow_control_select == 2'h1) [*2]
    |-> dtr_pin == !$past(busy)) else $error("dtr wrong in mark mode");
  a_dtr_xon_idle: assert property ((flow_control_select == 2'h2) [*2]
    |-> !dtr_pin) else $error("dtr moved in xon mode");
  a_min_busy_hold: assert property ($fell(busy) && min_busy_enable
    |-> busy_run_ff >= (min_busy_long ? MIN_BUSY_L_CYC : MIN_BUSY_S_CYC))
    else $error("busy released early");
  a_error_one_cycle: assert property (parity_error || framing_error
    |=> !parity_error && !framing_error) else $error("error pulse too long");
  a_seven_bit_data: assert property (len7 && rx_valid |-> !rx_data[7])
    else $error("bit 7 set");
  a_framing_drop: assert property (framing_error && !rx_valid |=> !rx_valid)
    else $error("bad frame stored");
  a_parity_kept: assert property (parity_error && !rx_valid |=> rx_valid)
    else $error("parity char lost");
  a_cfg_capture: assert property (cfg_load |=>
    flow_control_select == $past(nv_flow_control_select) && baud_select == $past(nv_baud_select)
    && len7 == $past(nv_len7)) else $error("settings not taken");
  a_rts_space: assert property (!rts_pin) else $error("rts not space");

  c_busy_release: cover property ($fell(busy));
  c_parity_error: cover property (parity_error);
  c_framing_error: cover property (framing_error);
endmodule

bind pscfc_top pscfc_top_properties #(
  .MIN_BUSY_S_CYC(MIN_BUSY_S_CYC),
  .MIN_BUSY_L_CYC(MIN_BUSY_L_CYC)
) props_u (
  .clock(clock), .nrst(nrst), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .busy(busy),
  .parity_error(parity_error), .framing_error(framing_error), .rx_valid(rx_valid),
  .rx_data(rx_data), .cfg_load(cfg_load), .nv_flow_control_select(nv_flow_control_select),
  .nv_baud_select(nv_baud_select), .nv_len7(nv_len7), .min_busy_enable(min_busy_enable),
  .flow_control_select(flow_control_select), .baud_select(baud_select), .len7(len7),
  .min_busy_long(min_busy_long)
);
`default_nettype wire

// file: verification/pscfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pscfc_host_model #(
  parameter int BIT_CLKS = 2604
) (
  // Clock.
  input  wire logic       clock,
  // Serial lines.
  output logic            line_to_dev,
  input  wire logic       line_from_dev,
  // Data and parity bits in each frame the device sends.
  input  wire logic [3:0] frame_bits
);
  logic [7:0] heard_q[$];
  logic [8:0] acc;

  initial line_to_dev = 1'b1;

  // Bits go out LSB first with the start bit at index zero.
  task automatic send(input logic [10:0] f, input int n, input int bclk);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      line_to_dev = f[i];
      // A low stop bit is cut short so the receiver drops the false start it sees when it checks half a bit in.
      repeat ((i == n - 1 && !f[i]) ? bclk * 6 / 10 : bclk - 1) @(negedge clock);
    end
    @(negedge clock);
    line_to_dev = 1'b1;
  endtask

  // Frames from the device are sampled at mid-bit.
  always begin
    @(negedge line_from_dev);
    repeat (BIT_CLKS / 2) @(posedge clock);
    acc = 9'h000;
    for (int i = 0; i < int'(frame_bits); i++) begin
      repeat (BIT_CLKS) @(posedge clock);
      acc[i] = line_from_dev;
    end
    heard_q.push_back(acc[7:0]);
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BIT = 2604;
  logic       clock, nrst, cfg_load, nv_l, nv_lg, mb_en, rx_ready, rx_line;
  logic [1:0] nv_f, nv_p, f_out, p_out;
  logic [2:0] nv_b, b_out;
  logic       tx, rts, dtr, l_out, lg_out, rx_valid, busy, perr, ferr, ovr;
  logic [7:0] rx_data;
  logic [3:0] dev_bits;
  int         fails, comparisons, cycles, perr_n, ferr_n, rise_at;
  logic       busy_d;

  pscfc_top #(.XON_PERIOD_CYC(2000), .MIN_BUSY_S_CYC(500), .MIN_BUSY_L_CYC(1500)) dut_u (
    .clock(clock), .nrst(nrst), .clk_en(1'b1), .rx_pin(rx_line), .tx_pin(tx), .rts_pin(rts),
    .dtr_pin(dtr), .cfg_load(cfg_load), .nv_flow_control_select(nv_f), .nv_baud_select(nv_b),
    .nv_len7(nv_l), .nv_parity_select(nv_p), .nv_min_busy_long(nv_lg), .min_busy_enable(mb_en),
    .flow_control_select(f_out), .baud_select(b_out), .len7(l_out), .parity_select(p_out),
    .min_busy_long(lg_out), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .busy(busy), .parity_error(perr), .framing_error(ferr), .overrun(ovr));

  pscfc_host_model #(.BIT_CLKS(BIT)) host_u (
    .clock(clock), .line_to_dev(rx_line), .line_from_dev(tx), .frame_bits(dev_bits));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Error pulses last one cycle, so they are counted here rather than polled.
  always @(posedge clock) begin
    cycles++;
    if (perr === 1'b1) perr_n++;
    if (ferr === 1'b1) ferr_n++;
    if (busy === 1'b1 && busy_d !== 1'b1) rise_at = cycles;
    busy_d = busy;
    if (cycles == 700000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic load(input logic [1:0] f, input logic [2:0] b, input logic l,
                      input logic [1:0] p, input logic lg);
    @(negedge clock);
    {nv_f, nv_b, nv_l, nv_p, nv_lg} = {f, b, l, p, lg};
    dev_bits = (l ? 4'h7 : 4'h8) + {3'h0, p != 2'h0};
    cfg_load = 1'b1;
    @(negedge clock);
    cfg_load = 1'b0;
    check({f_out, b_out, l_out, p_out}, {f, b, l, p});
    check(lg_out, lg);
  endtask

  task automatic host_char(input logic [7:0] d, input logic [1:0] p, input logic l,
                           input logic stop, input int bclk);
    logic [10:0] f;
    int          n;
    f = 11'h7FF;
    n = l ? 7 : 8;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i + 1] = d[i];
    if (p != 2'h0) begin
      f[n + 1] = ^(d & (l ? 8'h7F : 8'hFF)) ^ (p == 2'h2);
      n++;
    end
    f[n + 1] = stop;
    host_u.send(f, n + 2, bclk);
  endtask

  task automatic pop(input logic [7:0] want);
    for (int i = 0; i < 8 && rx_valid !== 1'b1; i++) @(negedge clock);
    check(rx_valid, 1'b1);
    check(rx_data, want);
    rx_ready = 1'b1;
    @(negedge clock);
    rx_ready = 1'b0;
    @(negedge clock);
  endtask

  task automatic test_defaults();
    check({f_out, b_out, l_out, p_out}, 8'h28);
    check({dtr, tx, busy, lg_out, ovr, rx_valid}, 8'h10);
  endtask

  task automatic test_xonxoff();
    load(2'h2, 3'h6, 1'b0, 2'h0, 1'b0);
    for (int i = 0; i < 3000 && {tx, dtr} === 2'h2; i++) @(negedge clock);
    check({tx, dtr}, 8'h02);
  endtask

  task automatic test_parity();
    load(2'h1, 3'h6, 1'b0, 2'h1, 1'b0);
    repeat (2) @(negedge clock);
    check(dtr, 1'b1);
    host_char(8'hA5, 2'h1, 1'b0, 1'b1, BIT * 102 / 100);
    pop(8'hA5);
    host_char(8'h3C, 2'h2, 1'b0, 1'b1, BIT);
    pop(8'h3C);
    check(perr_n[7:0], 8'h01);
    host_char(8'h5A, 2'h1, 1'b0, 1'b0, BIT);
    // The cut stop bit looks like a start edge; let the receiver reject it first.
    repeat (BIT) @(negedge clock);
    check({ferr_n[6:0], rx_valid}, 8'h02);
    load(2'h1, 3'h6, 1'b0, 2'h2, 1'b0);
    host_char(8'h01, 2'h2, 1'b0, 1'b1, BIT);
    pop(8'h01);
    check(perr_n[7:0], 8'h01);
  endtask

  task automatic test_busy_hold();
    load(2'h3, 3'h6, 1'b1, 2'h0, 1'b1);
    mb_en = 1'b1;
    for (int i = 0; i < 12; i++) begin
      check(busy, 1'b0);
      host_char(8'hC0 | 8'(i), 2'h0, 1'b1, 1'b1, BIT);
    end
    check(busy, 1'b1);
    repeat (2) @(negedge clock);
    check(dtr, 1'b1);
    check(host_u.heard_q.size() > 0, 1'b1);
    check(host_u.heard_q[0], 8'h11);
    for (int i = 0; i < 8; i++) pop(8'h40 | 8'(i));
    check(busy, 1'b1);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock);
    check(busy, 1'b0);
    check(cycles - rise_at >= 1499, 1'b1);
    repeat (2) @(negedge clock);
    check(dtr, 1'b0);
    for (int i = 8; i < 12; i++) pop(8'h40 | 8'(i));
  endtask

  initial begin
    {nrst, cfg_load, nv_f, nv_b, nv_l, nv_p, nv_lg, mb_en, rx_ready} = '0;
    dev_bits = 4'h8;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    test_defaults();
    test_xonxoff();
    test_parity();
    test_busy_hold();
    final_report();
  end
endmodule
`default_nettype wire
